// File: rgvb_defines.svh
`ifndef RGVB_DEFINES_SVH
`define RGVB_DEFINES_SVH
// register address of the regulator control register
`define RGVB_ADDR_REGCTL 8'hC9
// control register field positions
`define RGVB_BIT_IN_OFF 3
`define RGVB_BIT_VBUS 6
`define RGVB_BIT_IN_LP 4
`define RGVB_BIT_STOP_SD 3
`define RGVB_BIT_CORE_LP 1
`define RGVB_BIT_IN_OFF_POS 7
// reset value of the control register
`define RGVB_REGCTL_RST 8'h00
// writable bits (reserved bits also store, software writes zero there)
`define RGVB_REGCTL_WMASK 8'hBF
// interrupt status / mask register and its event bits
`define RGVB_ADDR_IRQ_STAT 8'hCA
`define RGVB_ADDR_IRQ_MASK 8'hCB
`define RGVB_BIT_EV_RISE 0
`define RGVB_BIT_EV_FALL 1
`define RGVB_IRQ_RST 8'h00
// reset-source select register (bit 0 routes bus-power edges to reset)
`define RGVB_ADDR_RSTSEL 8'hCC
`define RGVB_BIT_RSTSEL_USB 0
`endif

// File: rgvb_pkg.sv
package rgvb_pkg;
	// power state of the core supply
	typedef enum logic [1:0] {
		RGVB_RUN,
		RGVB_STOP_ON,
		RGVB_STOP_OFF
	} rgvb_pwr_type;
endpackage

// File: rgvb_sync.sv
`timescale 1ns/1ns
`default_nettype none
// three-stage synchroniser with edge pulses from stages two and three
module rgvb_sync (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// asynchronous input
	input wire logic async_in,
	// synchronised level and edges
	output logic level,
	output logic rise,
	output logic fall
);
	logic s1_r; // first stage, read only by s2_r
	logic s2_r;
	logic s3_r;

	// shift chain; reset to absent bus power
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// a change counts once stages two and three agree on it
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			level <= 1'b0;
		end else if (s2_r == s3_r) begin
			level <= s3_r;
		end
	end

	assign rise = (s2_r == s3_r) && s3_r && !level;
	assign fall = (s2_r == s3_r) && !s3_r && level;
endmodule
`default_nettype wire

// File: rgvb_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "rgvb_defines.svh"
module rgvb_ctrl
	import rgvb_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// bus power pin
	input wire logic vbus_pin,
	// power management from the core
	input wire logic stop_req,
	input wire logic wake_evt,
	input wire logic vbus_irq_en,
	// regulator controls
	output logic input_supply_en,
	output logic input_supply_low_power,
	output logic core_supply_en,
	output logic core_supply_low_power,
	// interrupts and reset
	output logic vbus_edge_irq,
	output logic irq,
	output logic usb_reset_req
);
	logic [7:0] regctl_r; // control register, bit 6 not stored
	logic [7:0] irq_stat_r; // sticky edge status for the level interrupt
	logic [7:0] irq_mask_r; // interrupt mask
	logic [7:0] rstsel_r; // reset-source select
	logic [7:0] rdata_nxt; // read mux
	logic vb_level; // synchronised bus power
	logic vb_rise;
	logic vb_fall;
	logic vb_edge;
	rgvb_pwr_type pwr_r; // stop state of the core supply

	// three flops on the pin, edges counted once
	rgvb_sync u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in(vbus_pin),
		.level(vb_level),
		.rise(vb_rise),
		.fall(vb_fall)
	);
	assign vb_edge = vb_rise | vb_fall;

	// control register; reserved bits store what software wrote
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			regctl_r <= `RGVB_REGCTL_RST;
		end else if (reg_wr && reg_addr == `RGVB_ADDR_REGCTL) begin
			regctl_r <= reg_wdata & `RGVB_REGCTL_WMASK;
		end
	end

	// status register: set wins over write-one-to-clear
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irq_stat_r <= `RGVB_IRQ_RST;
		end else begin
			if (reg_wr && reg_addr == `RGVB_ADDR_IRQ_STAT) begin
				irq_stat_r <= irq_stat_r & ~reg_wdata;
			end
			if (vb_rise) begin
				irq_stat_r[`RGVB_BIT_EV_RISE] <= 1'b1;
			end
			if (vb_fall) begin
				irq_stat_r[`RGVB_BIT_EV_FALL] <= 1'b1;
			end
		end
	end

	// mask and reset-select registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irq_mask_r <= `RGVB_IRQ_RST;
			rstsel_r <= `RGVB_IRQ_RST;
		end else if (reg_wr) begin
			if (reg_addr == `RGVB_ADDR_IRQ_MASK) begin
				irq_mask_r <= reg_wdata;
			end
			if (reg_addr == `RGVB_ADDR_RSTSEL) begin
				rstsel_r <= reg_wdata;
			end
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		rdata_nxt = 8'h00;
		case (reg_addr)
			`RGVB_ADDR_REGCTL: begin
				rdata_nxt = regctl_r;
				rdata_nxt[`RGVB_BIT_VBUS] = vb_level;
			end
			`RGVB_ADDR_IRQ_STAT: begin
				rdata_nxt = irq_stat_r;
			end
			`RGVB_ADDR_IRQ_MASK: begin
				rdata_nxt = irq_mask_r;
			end
			`RGVB_ADDR_RSTSEL: begin
				rdata_nxt = rstsel_r;
			end
			default: begin
				rdata_nxt = 8'h00;
			end
		endcase
	end

	// read data stand the cycle after the strobe only
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// stop handling: core supply drops only when configured to
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pwr_r <= RGVB_RUN;
		end else begin
			case (pwr_r)
				RGVB_RUN: begin
					if (stop_req) begin
						if (regctl_r[`RGVB_BIT_STOP_SD]) begin
							pwr_r <= RGVB_STOP_OFF;
						end else begin
							pwr_r <= RGVB_STOP_ON;
						end
					end
				end
				RGVB_STOP_ON: begin
					// only a wake or the reset pin ends stop with supply up; a usb reset request does not
					if (wake_evt) begin
						pwr_r <= RGVB_RUN;
					end
				end
				RGVB_STOP_OFF: begin
					// only the reset pin or power cycle recovers; nothing here
					pwr_r <= RGVB_STOP_OFF;
				end
				default: begin
					pwr_r <= RGVB_RUN;
				end
			endcase
		end
	end

	// regulator controls; low power is not forced off, software keeps the
	// restriction against core low power with input regulator disabled
	assign input_supply_en = !regctl_r[`RGVB_BIT_IN_OFF_POS];
	assign input_supply_low_power = regctl_r[`RGVB_BIT_IN_LP];
	assign core_supply_low_power = regctl_r[`RGVB_BIT_CORE_LP];
	assign core_supply_en = (pwr_r != RGVB_STOP_OFF);

	// edge interrupt: one pulse per edge, no flag held
	assign vbus_edge_irq = vbus_irq_en && vb_edge;
	// reset request on either edge when usb is a reset source
	assign usb_reset_req = rstsel_r[`RGVB_BIT_RSTSEL_USB] && vb_edge;
	// level interrupt from sticky status under mask
	assign irq = |(irq_stat_r & irq_mask_r);

	chk_edge_irq_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
		(vbus_irq_en && $changed(vb_level)) |-> $past(vbus_edge_irq))
		else $error("edge interrupt missing for bus-power change");
	chk_no_pending_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		vbus_edge_irq |=> !vbus_edge_irq)
		else $error("edge interrupt held longer than one cycle");
	chk_status_tracks_bus: assert property (@(posedge core_clk) disable iff (!rst_n)
		(reg_rd && reg_addr == `RGVB_ADDR_REGCTL) |=> reg_rdata[`RGVB_BIT_VBUS] == $past(vb_level))
		else $error("bus-power status bit wrong");
	chk_usb_reset_edge: assert property (@(posedge core_clk) disable iff (!rst_n)
		(rstsel_r[`RGVB_BIT_RSTSEL_USB] && $changed(vb_level)) |-> $past(usb_reset_req))
		else $error("usb reset not requested on edge");
	chk_stop_keep_core: assert property (@(posedge core_clk) disable iff (!rst_n)
		(pwr_r == RGVB_RUN && stop_req && !regctl_r[`RGVB_BIT_STOP_SD]) |=> core_supply_en)
		else $error("core supply dropped in default stop");
	chk_stop_shutdown: assert property (@(posedge core_clk) disable iff (!rst_n)
		(pwr_r == RGVB_RUN && stop_req && regctl_r[`RGVB_BIT_STOP_SD]) |=> !core_supply_en [*3])
		else $error("core supply not shut in configured stop");
	chk_input_off_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == `RGVB_ADDR_REGCTL) |=> input_supply_en == !$past(reg_wdata[`RGVB_BIT_IN_OFF_POS]))
		else $error("input regulator enable does not follow control bit");
	chk_low_power_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == `RGVB_ADDR_REGCTL) |=>
		(input_supply_low_power == $past(reg_wdata[`RGVB_BIT_IN_LP])) &&
		(core_supply_low_power == $past(reg_wdata[`RGVB_BIT_CORE_LP])))
		else $error("low-power bits do not follow control register");
	chk_single_edge: assert property (@(posedge core_clk) disable iff (!rst_n)
		!(vb_rise && vb_fall))
		else $error("rise and fall in the same cycle");

	// reset leaves the control register at its documented value
	// checked without disable so the reset branch itself is covered
	chk_ctl_reset_val: assert property (@(posedge core_clk)
		!rst_n |=> (regctl_r == `RGVB_REGCTL_RST))
		else $error("control register not cleared by reset");

	// side registers also come out of reset empty
	// a stale mask or reset select would fire events after reset
	chk_regs_reset_zero: assert property (@(posedge core_clk)
		!rst_n |=> (irq_stat_r == `RGVB_IRQ_RST) && (irq_mask_r == `RGVB_IRQ_RST) && (rstsel_r == `RGVB_IRQ_RST))
		else $error("status, mask or reset select not cleared by reset");

	// reset is the only way out of the shutdown stop state
	// so reset must land the power state in run
	chk_pwr_reset: assert property (@(posedge core_clk)
		!rst_n |=> (pwr_r == RGVB_RUN))
		else $error("power state not run after reset");

	// read data are zero unless a read strobe came the cycle before
	// keeps a stale value from being taken for a fresh read
	chk_rdata_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
		!reg_rd |=> (reg_rdata == 8'h00))
		else $error("read data not zero outside a read");

	// control read returns the stored bits beside the live status bit
	// the status bit is covered by its own check
	chk_rdata_ctl: assert property (@(posedge core_clk) disable iff (!rst_n)
		(reg_rd && reg_addr == `RGVB_ADDR_REGCTL) |=>
		((reg_rdata & `RGVB_REGCTL_WMASK) == ($past(regctl_r) & `RGVB_REGCTL_WMASK)))
		else $error("control register read back wrong");

	// the status position is never stored
	// a stored copy could disagree with the live bus level
	chk_vbus_bit_ro: assert property (@(posedge core_clk) disable iff (!rst_n)
		!regctl_r[`RGVB_BIT_VBUS])
		else $error("status bit stored in control register");

	// a control write lands with the read-only bit masked
	// reserved bits keep what software wrote there
	chk_ctl_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == `RGVB_ADDR_REGCTL) |=> (regctl_r == ($past(reg_wdata) & `RGVB_REGCTL_WMASK)))
		else $error("control write not stored");

	// without a control write the register holds
	// catches writes decoded from the wrong address
	chk_ctl_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		!(reg_wr && reg_addr == `RGVB_ADDR_REGCTL) |=> $stable(regctl_r))
		else $error("control register changed without a write");

	// a rising edge leaves its status bit set
	// set wins even when software clears in the same cycle
	chk_rise_sets_stat: assert property (@(posedge core_clk) disable iff (!rst_n)
		vb_rise |=> irq_stat_r[`RGVB_BIT_EV_RISE])
		else $error("rise did not set its status bit");

	// a falling edge leaves its status bit set
	// same set-wins priority as the rise bit
	chk_fall_sets_stat: assert property (@(posedge core_clk) disable iff (!rst_n)
		vb_fall |=> irq_stat_r[`RGVB_BIT_EV_FALL])
		else $error("fall did not set its status bit");

	// writing ones clears those status bits when no edge competes
	// other bits are left alone
	chk_stat_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == `RGVB_ADDR_IRQ_STAT && !vb_rise && !vb_fall) |=>
		((irq_stat_r & $past(reg_wdata)) == 8'h00))
		else $error("status write did not clear");

	// with no edge and no clear the status holds
	// sticky bits must not leak away on their own
	chk_stat_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!(reg_wr && reg_addr == `RGVB_ADDR_IRQ_STAT) && !vb_rise && !vb_fall) |=> $stable(irq_stat_r))
		else $error("status changed without event or clear");

	// an edge pulse is always followed by a level change
	// a pulse without a real transition would be a spurious event
	chk_edge_needs_change: assert property (@(posedge core_clk) disable iff (!rst_n)
		vbus_edge_irq |=> $changed(vb_level))
		else $error("edge interrupt without bus-power change");

	// a reset request likewise needs a real transition
	// a false request would reset the whole device
	chk_reset_needs_edge: assert property (@(posedge core_clk) disable iff (!rst_n)
		usb_reset_req |=> $changed(vb_level))
		else $error("usb reset without bus-power change");

	// no edge interrupt while it is disabled
	// the reset request path is independent of this enable
	chk_edge_irq_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		!vbus_irq_en |-> !vbus_edge_irq)
		else $error("edge interrupt while disabled");

	// a reset request is one cycle long
	// a held request would count as several resets downstream
	chk_usb_reset_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
		usb_reset_req |=> !usb_reset_req)
		else $error("usb reset request longer than one cycle");

	// shutdown stop is left only through reset
	// wake events are ignored once the core supply is gone
	chk_stop_off_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
		(pwr_r == RGVB_STOP_OFF) |=> (pwr_r == RGVB_STOP_OFF))
		else $error("shutdown stop left without reset");

	// with the supply kept a wake ends stop
	// only wake_evt or the reset pin brings the core back, a usb reset request does not
	chk_stop_on_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
		(pwr_r == RGVB_STOP_ON && wake_evt) |=> (pwr_r == RGVB_RUN))
		else $error("wake did not end stop");

	// stop with the supply kept waits for a wake
	// leaving early would skip the wake source entirely
	chk_stop_on_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
		(pwr_r == RGVB_STOP_ON && !wake_evt) |=> (pwr_r == RGVB_STOP_ON))
		else $error("stop left without a wake");

	// run is left only on a stop request
	// guards against the core supply dropping in normal work
	chk_run_stays: assert property (@(posedge core_clk) disable iff (!rst_n)
		(pwr_r == RGVB_RUN && !stop_req) |=> (pwr_r == RGVB_RUN))
		else $error("left run without a stop request");

	// mask writes land as written
	// the mask has no reserved bits of its own
	chk_mask_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == `RGVB_ADDR_IRQ_MASK) |=> (irq_mask_r == $past(reg_wdata)))
		else $error("mask write not stored");

	// reset-select writes land as written
	// the usb source bit gates the reset request
	chk_rstsel_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == `RGVB_ADDR_RSTSEL) |=> (rstsel_r == $past(reg_wdata)))
		else $error("reset select write not stored");

	// status read returns the sticky bits as they stood at the strobe
	// an edge in the read cycle shows up on the next read
	chk_rdata_stat: assert property (@(posedge core_clk) disable iff (!rst_n)
		(reg_rd && reg_addr == `RGVB_ADDR_IRQ_STAT) |=> (reg_rdata == $past(irq_stat_r)))
		else $error("status read back wrong");
endmodule
`default_nettype wire

// File: rgvb_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
// bus power cable and system reset controller facing the device
module rgvb_bus_model (
	// clock
	input wire logic core_clk,
	// cable plugged in or not, from the bench
	input wire logic attach,
	// requests from the device
	input wire logic usb_reset_req,
	input wire logic vbus_edge_irq,
	// cable level and event counts
	output logic vbus_pin,
	output logic [7:0] rst_cnt,
	output logic [7:0] edge_cnt
);
	// the cable level has no pull, it just follows the plug
	assign vbus_pin = attach;
	// counters start clean, since this model has no reset of its own
	initial begin
		rst_cnt = 8'h00;
		edge_cnt = 8'h00;
	end
	// count each one-cycle request; a stretched pulse counts once per cycle it is high
	always @(posedge core_clk) begin
		if (usb_reset_req === 1'b1) begin
			rst_cnt <= rst_cnt + 8'h01;
		end
		if (vbus_edge_irq === 1'b1) begin
			edge_cnt <= edge_cnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "rgvb_defines.svh"
module testbench;
	// clock, reset and register port
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	// power management inputs
	logic stop_req = 1'b0;
	logic wake_evt = 1'b0;
	logic vbus_irq_en = 1'b0;
	logic attach = 1'b0;
	// device outputs and model counts
	logic vbus_pin;
	logic input_supply_en;
	logic input_supply_low_power;
	logic core_supply_en;
	logic core_supply_low_power;
	logic vbus_edge_irq;
	logic irq;
	logic usb_reset_req;
	logic [7:0] rst_cnt;
	logic [7:0] edge_cnt;
	int err_total = 0;
	int checks_done = 0;
	// 125 MHz clock
	always #4 core_clk = ~core_clk;
	rgvb_bus_model rgvb_bus_model_i (.core_clk(core_clk), .attach(attach), .usb_reset_req(usb_reset_req),
		.vbus_edge_irq(vbus_edge_irq), .vbus_pin(vbus_pin), .rst_cnt(rst_cnt), .edge_cnt(edge_cnt));
	rgvb_ctrl rgvb_ctrl_i (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vbus_pin(vbus_pin), .stop_req(stop_req),
		.wake_evt(wake_evt), .vbus_irq_en(vbus_irq_en), .input_supply_en(input_supply_en),
		.input_supply_low_power(input_supply_low_power), .core_supply_en(core_supply_en),
		.core_supply_low_power(core_supply_low_power), .vbus_edge_irq(vbus_edge_irq), .irq(irq),
		.usb_reset_req(usb_reset_req));
	// compare one value, count and report
	task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one-cycle write strobe
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// one-cycle read strobe, data looked at in the following cycle only
	task rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(what, reg_rdata, exp);
	endtask
	// enter stop with a given config, then try a wake; supply must match both times
	task stop_cycle(input logic [7:0] cfg, input logic [7:0] exp_en);
		wr(`RGVB_ADDR_REGCTL, cfg);
		stop_req <= 1'b1;
		@(posedge core_clk);
		stop_req <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1 chk("core_en_stop", {7'h00, core_supply_en}, exp_en);
		@(posedge core_clk);
		wake_evt <= 1'b1;
		@(posedge core_clk);
		wake_evt <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1 chk("core_en_wake", {7'h00, core_supply_en}, exp_en);
	endtask
	// move the cable, then give the synchroniser time to settle
	task plug(input logic lvl);
		@(posedge core_clk);
		attach <= lvl;
		repeat (12) @(posedge core_clk);
		#1;
	endtask
	// print the counts and the verdict, then stop
	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(`RGVB_ADDR_REGCTL, 8'h00, "ctl_reset");
		chk("supplies_on", {6'h00, input_supply_en, core_supply_en}, 8'h03);
		rd(8'h00, 8'h00, "unmapped");
		// low power only while the input regulator stays on
		wr(`RGVB_ADDR_REGCTL, 8'h12);
		repeat (12) @(posedge core_clk);
		rd(`RGVB_ADDR_REGCTL, 8'h12, "ctl_lp");
		chk("lp_outs", {6'h00, input_supply_low_power, core_supply_low_power}, 8'h03);
		// input regulator off, core low power left clear, status bit not writable
		wr(`RGVB_ADDR_REGCTL, 8'hFD);
		rd(`RGVB_ADDR_REGCTL, 8'hBD, "ctl_off");
		chk("in_off", {7'h00, input_supply_en}, 8'h00);
		wr(`RGVB_ADDR_REGCTL, 8'h00);
		wr(`RGVB_ADDR_IRQ_MASK, 8'h03);
		wr(`RGVB_ADDR_RSTSEL, 8'h01);
		// rise with the edge interrupt off still resets
		plug(1'b1);
		chk("edge_off", edge_cnt, 8'h00);
		chk("rst_rise", rst_cnt, 8'h01);
		rd(`RGVB_ADDR_REGCTL, 8'h40, "vbus_hi");
		wr(`RGVB_ADDR_IRQ_STAT, 8'h03);
		vbus_irq_en <= 1'b1;
		plug(1'b0);
		chk("edge_fall", edge_cnt, 8'h01);
		chk("rst_fall", rst_cnt, 8'h02);
		rd(`RGVB_ADDR_REGCTL, 8'h00, "vbus_lo");
		rd(`RGVB_ADDR_IRQ_STAT, 8'h02, "stat_fall");
		chk("irq_on", {7'h00, irq}, 8'h01);
		wr(`RGVB_ADDR_IRQ_STAT, 8'h02);
		rd(`RGVB_ADDR_IRQ_STAT, 8'h00, "stat_clr");
		chk("irq_clr", {7'h00, irq}, 8'h00);
		// a masked rise keeps the level line quiet, the pulse still comes
		wr(`RGVB_ADDR_IRQ_MASK, 8'h00);
		plug(1'b1);
		chk("edge_rise", edge_cnt, 8'h02);
		chk("irq_masked", {7'h00, irq}, 8'h00);
		// stop with the core supply kept, then with shutdown
		stop_cycle(8'h00, 8'h01);
		stop_cycle(8'h08, 8'h00);
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		#1 chk("core_en_rst", {7'h00, core_supply_en}, 8'h01);
		repeat (12) @(posedge core_clk);
		rd(`RGVB_ADDR_REGCTL, 8'h40, "ctl_after_rst");
		give_verdict();
	end
endmodule
`default_nettype wire
